// ### bus_arb_pkg.sv
// Package with register layout, reset values and timing counts for the internal bus arbiter.
package bus_arb_pkg;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam logic [7:0] CTRL_WMASK = 8'h11;
  localparam int WBUF_BIT = 0;
  localparam int FIXED_ONE_BIT = 1;
  localparam int ALT_BIT = 4;
  localparam logic [2:0] ROM_RD_CYC = 3'h1;
  localparam logic [2:0] RAM_RD_CYC = 3'h1;
  localparam logic [2:0] RAM_WR_CYC = 3'h2;
  localparam logic [2:0] SYSREG_RD_CYC = 3'h2;
  localparam logic [2:0] SYSREG_WR_CYC = 3'h3;
  localparam logic [2:0] PSLOW_RD_CYC = 3'h2;
  localparam logic [2:0] PSLOW_WR_CYC = 3'h3;
  localparam logic [2:0] PFAST_WR_CYC = 3'h2;
  localparam logic [2:0] SSU_WR_CYC = 3'h3;
  localparam logic [2:0] WBUF_SOLO_CYC = 3'h2;
  typedef enum logic [2:0] {
    SP_ROM,
    SP_RAM,
    SP_SYSREG,
    SP_PSLOW,
    SP_PFAST,
    SP_SSU
  } space_e;
  localparam int M_CPU = 0;
  localparam int M_ETC = 1;
  localparam int M_DMA = 2;
endpackage

// ### internal_bus_arbiter_ctrl.sv
// Internal bus arbiter with control register, access cycle timing and peripheral write buffer.
`timescale 1ns/1ps
// Function
// - Watch each master request and acknowledge a requesting master.
// - Among simultaneous requests, acknowledge only the highest priority requester.
// - Acknowledged master owns the bus until acknowledge is withdrawn at decision points.
// - Priority decided only at decision instants, among CPU, event controller and DMA.
// - CPU lowest; ownership leaves CPU at the end of its bus cycle.
// - Control bit 4 picks strict priority or alternating CPU and DMA/event cycles.
// - With bit 4 clear, DMA holds the bus through block and burst transfers.
// - DMA never releases between dual address read and its paired write.
// - Control register resets to 02; bits 7,6,5,3,2 read zero, bit 1 reads one.
// - Control bit 0 enables the peripheral write buffer, reset zero.
// - Buffered peripheral write runs alone two cycles, then counts down only while no access is busy.
// - ROM and RAM reads take one cycle, RAM writes two.
// - Peripheral-clock registers add 0 to n-1 sync cycles for a 1:n ratio.
// - System registers take two cycles to read, three to write, unbuffered.
// - Pin function and watchdog registers take 2/3 peripheral cycles, unbuffered.
// - Other peripheral writes take two peripheral cycles, sync serial three; bufferable.
// - Arbiter runs on the system clock; peripheral timing counts divided-clock cycles.
module internal_bus_arbiter_ctrl
  import bus_arb_pkg::*;
#(
  parameter int RATIO_W = 4
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] bus_req,
  input wire logic [2:0] hold_req,
  input wire logic dma_pair_hold,
  output logic [2:0] bus_ack,
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic [2:0] acc_space,
  input wire logic [RATIO_W-1:0] clock_ratio_control,
  output logic acc_done,
  output logic acc_busy,
  output logic wbuf_busy,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] bus_arbitration_control
);
  typedef enum logic [1:0] {
    A_IDLE,
    A_OWN
  } arb_e;
  typedef struct packed {
    arb_e arb;
    logic [2:0] ack;
    logic cpu_turn;
    logic [7:0] ctrl;
    logic busy;
    logic done;
    logic [3:0] cnt;
    logic [RATIO_W-1:0] div;
    logic [RATIO_W-1:0] sync;
    logic wb_busy;
    logic [3:0] wb_cnt;
  } state_s;
  state_s cur_ff;
  state_s nxt_s;
  logic [2:0] grant;
  logic decide;
  logic [3:0] acc_len;
  logic slow;
  logic bufferable;
  logic wb_en;
  logic alt;

  always_comb
  begin
    alt = cur_ff.ctrl[ALT_BIT];
    wb_en = cur_ff.ctrl[WBUF_BIT];
    slow = 1'b0;
    bufferable = 1'b0;
    acc_len = {1'b0, ROM_RD_CYC};
    case (space_e'(acc_space))
      SP_ROM: acc_len = {1'b0, ROM_RD_CYC};
      SP_RAM: acc_len = acc_write ? {1'b0, RAM_WR_CYC} : {1'b0, RAM_RD_CYC};
      SP_SYSREG: acc_len = acc_write ? {1'b0, SYSREG_WR_CYC} : {1'b0, SYSREG_RD_CYC};
      SP_PSLOW:
      begin
        slow = 1'b1;
        acc_len = acc_write ? {1'b0, PSLOW_WR_CYC} : {1'b0, PSLOW_RD_CYC};
      end
      SP_PFAST:
      begin
        slow = 1'b1;
        bufferable = acc_write;
        acc_len = acc_write ? {1'b0, PFAST_WR_CYC} : {1'b0, PSLOW_RD_CYC};
      end
      SP_SSU:
      begin
        slow = 1'b1;
        bufferable = acc_write;
        acc_len = acc_write ? {1'b0, SSU_WR_CYC} : {1'b0, PSLOW_RD_CYC};
      end
      default: acc_len = {1'b0, ROM_RD_CYC};
    endcase
    // Decision points: bus free, or owner finished its cycle and is not locked.
    decide = (cur_ff.arb == A_IDLE) || (!cur_ff.busy && !(cur_ff.ack[M_DMA] && dma_pair_hold)
      && !(cur_ff.ack[M_DMA] && hold_req[M_DMA] && !alt)
      && !(cur_ff.ack[M_ETC] && hold_req[M_ETC])
      && !(cur_ff.ack[M_CPU] && hold_req[M_CPU]));
    grant = 3'b000;
    if (bus_req[M_DMA])
      grant[M_DMA] = 1'b1;
    else if (bus_req[M_ETC])
      grant[M_ETC] = 1'b1;
    else if (bus_req[M_CPU])
      grant[M_CPU] = 1'b1;
    if (alt && bus_req[M_CPU] && cur_ff.cpu_turn && (bus_req[M_DMA] || bus_req[M_ETC]))
      grant = 3'b001;
    nxt_s = cur_ff;
    nxt_s.done = 1'b0;
    if (decide)
    begin
      nxt_s.ack = grant;
      nxt_s.arb = (grant != 3'b000) ? A_OWN : A_IDLE;
      if (grant != 3'b000)
        nxt_s.cpu_turn = !grant[M_CPU];
    end
    if (!bus_req[M_CPU])
      nxt_s.cpu_turn = 1'b0;
    nxt_s.div = (cur_ff.div >= clock_ratio_control - 1'b1 || clock_ratio_control == '0) ? '0 : cur_ff.div + 1'b1;
    if (acc_start && !cur_ff.busy)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.sync = '0;
      // Peripheral accesses wait for the next divided-clock edge, 0 to n-1 cycles.
      if (slow && cur_ff.div != '0)
        nxt_s.sync = clock_ratio_control - cur_ff.div;
      nxt_s.cnt = slow ? 4'(acc_len * clock_ratio_control) : acc_len;
      if (slow && clock_ratio_control == '0)
        nxt_s.cnt = acc_len;
      if (bufferable && wb_en && !cur_ff.wb_busy)
      begin
        nxt_s.wb_busy = 1'b1;
        nxt_s.wb_cnt = 4'(nxt_s.cnt - {1'b0, WBUF_SOLO_CYC});
        nxt_s.cnt = {1'b0, WBUF_SOLO_CYC};
      end
    end
    else if (cur_ff.busy)
    begin
      if (cur_ff.sync != '0)
        nxt_s.sync = cur_ff.sync - 1'b1;
      else if (cur_ff.cnt <= 4'h1)
      begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
      else
        nxt_s.cnt = cur_ff.cnt - 1'b1;
    end
    // Remaining buffered write cycles count down only while no later access is busy.
    if (cur_ff.wb_busy && !(cur_ff.busy && cur_ff.cnt != '0 && acc_start))
    begin
      if (cur_ff.wb_cnt == '0 || !cur_ff.busy)
        nxt_s.wb_cnt = (cur_ff.wb_cnt == '0) ? '0 : cur_ff.wb_cnt - 1'b1;
      if (cur_ff.wb_cnt <= 4'h1 && !cur_ff.busy)
        nxt_s.wb_busy = 1'b0;
    end
    if (ctrl_wr)
      nxt_s.ctrl = (ctrl_wdata & CTRL_WMASK) | CTRL_RESET;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_ff <= '0;
      cur_ff.ctrl <= CTRL_RESET;
    end
    else
      cur_ff <= nxt_s;
  end

  assign bus_ack = cur_ff.ack;
  assign acc_done = cur_ff.done;
  assign acc_busy = cur_ff.busy;
  assign wbuf_busy = cur_ff.wb_busy;
  assign bus_arbitration_control = cur_ff.ctrl;
endmodule

// ### internal_bus_arbiter_ctrl_assertions.sv
// Checker for the bus arbiter ports.
`timescale 1ns/1ps
module internal_bus_arbiter_ctrl_assertions
  import bus_arb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] bus_req,
  input wire logic [2:0] hold_req,
  input wire logic dma_pair_hold,
  input wire logic [2:0] bus_ack,
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic [2:0] acc_space,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] bus_arbitration_control
);
  wire alt = bus_arbitration_control[4];
  wire go = acc_start && !acc_busy;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_rom; go && acc_space == SP_ROM && !acc_write; endsequence
  sequence s_sysw; go && acc_space == SP_SYSREG && acc_write; endsequence
  property p_one; $onehot0(bus_ack); endproperty
  a_one: assert property (p_one) else $error("two grants");
  property p_rsv; bus_arbitration_control[1] && !(bus_arbitration_control & 8'hec); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  property p_wr; ctrl_wr |=> (bus_arbitration_control & 8'h11) == ($past(ctrl_wdata) & 8'h11); endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_req; bus_ack != 3'h0 |-> |(bus_ack & $past(bus_req)); endproperty
  a_req: assert property (p_req) else $error("grant without request");
  property p_dma; !alt && bus_ack == 3'h0 && bus_req[2] |=> bus_ack == 3'h4; endproperty
  a_dma: assert property (p_dma) else $error("dma not first");
  property p_etc; !alt && bus_ack == 3'h0 && bus_req == 3'h3 |=> bus_ack == 3'h2; endproperty
  a_etc: assert property (p_etc) else $error("cpu not lowest");
  property p_hold; bus_ack[2] && (dma_pair_hold || hold_req[2] && !alt) |=> bus_ack[2]; endproperty
  a_hold: assert property (p_hold) else $error("dma released early");
  property p_cpu; bus_ack[0] && hold_req[0] |=> bus_ack[0]; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu cycle cut");
  property p_rom; s_rom |-> ##2 acc_done; endproperty
  a_rom: assert property (p_rom) else $error("rom read length");
  property p_sys; s_sysw |-> ##4 acc_done; endproperty
  a_sys: assert property (p_sys) else $error("system write length");
endmodule
bind internal_bus_arbiter_ctrl internal_bus_arbiter_ctrl_assertions chk (.*);

// ### bus_master_model.sv
// Model of the three masters.
`timescale 1ns/1ps
module bus_master_model
(
  input wire logic [2:0] want,
  input wire logic [2:0] lock,
  input wire logic pair,
  input wire logic [2:0] bus_ack,
  output logic [2:0] bus_req,
  output logic [2:0] hold_req,
  output logic dma_pair_hold
);
  // Holds are only shown while owning, since a master cannot lock a bus it lacks.
  assign bus_req = want;
  assign hold_req = lock & bus_ack;
  assign dma_pair_hold = pair & bus_ack[2];
endmodule

// ### internal_bus_arbiter_ctrl_tb.sv
// Bench for the bus arbiter.
`timescale 1ns/1ps
module internal_bus_arbiter_ctrl_tb;
  import bus_arb_pkg::*;
  logic sys_clk = 0, resetn = 0, acc_start = 0, acc_write = 0, ctrl_wr = 0, pair = 0;
  logic acc_done, acc_busy, wbuf_busy, dma_pair_hold;
  logic [2:0] want = 0, lock = 0, acc_space = 0, bus_req, hold_req, bus_ack;
  logic [3:0] ratio = 4'h1;
  logic [7:0] ctrl_wdata = 0, ctrl_rd;
  int bad_count = 0, check_count = 0, cyc = 0, n, k;
  // High byte: want, alternate bit, grant; low byte: space, write, cycles.
  logic [15:0] rows [9] = '{16'h1102, 16'h2222, 16'h4433, 16'h3243, 16'h6454, 16'h7463, 16'h6c74, 16'h1993, 16'h00b4};
  internal_bus_arbiter_ctrl #(.RATIO_W(4)) DUT (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
    .hold_req(hold_req), .dma_pair_hold(dma_pair_hold), .bus_ack(bus_ack), .acc_start(acc_start),
    .acc_write(acc_write), .acc_space(acc_space), .clock_ratio_control(ratio), .acc_done(acc_done),
    .acc_busy(acc_busy), .wbuf_busy(wbuf_busy), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .bus_arbitration_control(ctrl_rd));
  bus_master_model masters (.want(want), .lock(lock), .pair(pair), .bus_ack(bus_ack), .bus_req(bus_req),
    .hold_req(hold_req), .dma_pair_hold(dma_pair_hold));
  initial forever #20 sys_clk = ~sys_clk;
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  task cwr(input logic [7:0] d);
    ctrl_wr = 1;
    ctrl_wdata = d;
    step;
    ctrl_wr = 0;
  endtask
  task acc(input logic [7:0] r);
    {acc_space, acc_write, acc_start} = {r[7:4], 1'b1};
    step;
    acc_start = 0;
    for (n = 1; acc_done !== 1'b1 && n < 40; n++)
      step;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (5) step;
    resetn = 1;
    step;
    check(ctrl_rd, 8'h02);
    cwr(8'hff);
    check(ctrl_rd, 8'h13);
    foreach (rows[i])
    begin
      cwr({3'h0, rows[i][11], 4'h2});
      want = rows[i][14:12];
      repeat (4) step;
      check(8'(bus_ack), 8'(rows[i][10:8]));
      want = 0;
      acc(rows[i][7:0]);
      check(8'(n), 8'(rows[i][3:0]));
      step;
    end
    cwr(8'h12);
    want = 3'h5;
    k = 0;
    repeat (8)
    begin
      step;
      k += bus_ack[0];
    end
    check(8'(k >= 3 && k <= 5), 8'h01);
    pair = 1;
    repeat (3) step;
    check(8'(bus_ack), 8'h04);
    cwr(8'h02);
    {pair, want, lock} = 7'h09;
    repeat (3) step;
    want = 3'h5;
    repeat (3) step;
    check(8'(bus_ack), 8'h01);
    lock = 0;
    repeat (3) step;
    check(8'(bus_ack), 8'h04);
    {want, ratio} = 7'h02;
    cwr(8'h03);
    acc(8'h90);
    check(8'(n >= 3 && n <= 4), 8'h01);
    check(8'(wbuf_busy), 8'h01);
    check(8'(acc_busy), 8'h00);
    complete_run;
  end
endmodule
